/* design/pwm_duty_phase_trigger.sv */
// What this block does
// - software-written 16-bit duty value compared with time base forms output pulse
// - independent-period select low: phase register shifts outputs in pairings 00, 01, 10
// - independent-period select high: phase register is this generator's own period in pairings 00, 01, 10
// - trigger output passes every (n+1)th trigger event, n the 4-bit divide field
// - after enable, wait start-delay PWM cycles (0 to 63) before first trigger event
// - secondary generator never raises trigger interrupts; only primary does
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_phase_trigger
  import pwm_pkg::*;
#(
  parameter bit secondary_gen = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic high_side_output,
  output logic low_side_output,
  output logic trigger_out,
  output logic irq
);
  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [15:0] duty_value_q;
  logic [15:0] phase_offset_q;
  logic [15:0] trigger_control_q;
  logic [15:0] generator_control_q;
  logic [15:0] output_control_q;
  logic [15:0] period_value_q;
  logic [15:0] irq_status_q;
  logic [15:0] irq_status_d;
  logic [15:0] irq_mask_q;
  logic [15:0] rd_data_d;

  logic gen_en;
  logic ipsel;
  logic [1:0] pairing;
  logic [3:0] trigger_divide;
  logic [5:0] trigger_start_delay;

  assign gen_en = generator_control_q[gen_enable_bit];
  assign ipsel = generator_control_q[independent_period_select_bit];
  assign pairing = output_control_q[output_pairing_hi:output_pairing_lo];
  assign trigger_divide = trigger_control_q[trigger_divide_hi:trigger_divide_lo];
  assign trigger_start_delay =
    trigger_control_q[trigger_start_delay_hi:trigger_start_delay_lo];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      duty_value_q <= reg_reset;
    else if (wr_en && addr == duty_value_addr)
      duty_value_q <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      phase_offset_q <= reg_reset;
      trigger_control_q <= reg_reset;
      generator_control_q <= reg_reset;
      output_control_q <= reg_reset;
      period_value_q <= reg_reset;
      irq_mask_q <= reg_reset;
    end
    else if (wr_en)
    begin
      if (addr == phase_offset_addr)
        phase_offset_q <= wr_data;
      else if (addr == trigger_control_addr)
        trigger_control_q <= wr_data & trigger_control_mask;
      else if (addr == generator_control_addr)
        generator_control_q <= wr_data & generator_control_mask;
      else if (addr == output_control_addr)
        output_control_q <= wr_data & output_control_mask;
      else if (addr == period_value_addr)
        period_value_q <= wr_data;
      else if (addr == irq_mask_addr)
        irq_mask_q <= wr_data & irq_bits_mask;
    end
  end

  always_comb
  begin
    rd_data_d = 16'h0000;
    if (addr == duty_value_addr)
      rd_data_d = duty_value_q;
    else if (addr == phase_offset_addr)
      rd_data_d = phase_offset_q;
    else if (addr == trigger_control_addr)
      rd_data_d = trigger_control_q;
    else if (addr == generator_control_addr)
      rd_data_d = generator_control_q;
    else if (addr == output_control_addr)
      rd_data_d = output_control_q;
    else if (addr == period_value_addr)
      rd_data_d = period_value_q;
    else if (addr == irq_status_addr)
      rd_data_d = irq_status_q;
    else if (addr == irq_mask_addr)
      rd_data_d = irq_mask_q;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data <= 16'h0000;
    else if (rd_en)
      rd_data <= rd_data_d;
    else
      rd_data <= 16'h0000;
  end

  // -----------------------------------------------------------------
  // enable edge
  // -----------------------------------------------------------------
  logic en_prev_q;
  logic start;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      en_prev_q <= 1'b0;
    else
      en_prev_q <= gen_en;
  end

  assign start = gen_en && !en_prev_q;

  // -----------------------------------------------------------------
  // time base
  // -----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] period_sel;
  logic phase_used;
  logic cycle_end;
  logic pp_q;

  assign phase_used = (pairing != pairing_independent);
  assign period_sel = (ipsel && phase_used) ? phase_offset_q : period_value_q;
  assign cycle_end = gen_en && !start && (cnt_q >= period_sel);

  always_ff @(posedge clk)
  begin
    if (!rst_b || !gen_en)
      cnt_q <= 16'h0000;
    else if (start)
      cnt_q <= (phase_used && !ipsel) ? phase_offset_q : 16'h0000;
    else if (cycle_end)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  // push-pull alternates sides each cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b || !gen_en)
      pp_q <= 1'b0;
    else if (cycle_end)
      pp_q <= !pp_q;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  logic pulse;

  assign pulse = (cnt_q < duty_value_q);

  always_ff @(posedge clk)
  begin
    if (!rst_b || !gen_en)
    begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
    end
    else
    begin
      case (pairing)
        pairing_complementary:
        begin
          high_side_output <= pulse;
          low_side_output <= !pulse;
        end
        pairing_redundant:
        begin
          high_side_output <= pulse;
          low_side_output <= pulse;
        end
        pairing_push_pull:
        begin
          high_side_output <= pulse && !pp_q;
          low_side_output <= pulse && pp_q;
        end
        default:
        begin
          high_side_output <= pulse;
          low_side_output <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // trigger
  // -----------------------------------------------------------------
  logic trig_pulse;

  trig_postscaler u_post
  (
    .clk(clk),
    .rst_b(rst_b),
    .restart(start),
    .event_in(cycle_end),
    .divide(trigger_divide),
    .start_delay(trigger_start_delay),
    .trig_out(trig_pulse)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      trigger_out <= 1'b0;
    else
      trigger_out <= trig_pulse;
  end

  // -----------------------------------------------------------------
  // interrupts
  // -----------------------------------------------------------------
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (rd_en && addr == irq_status_addr)
      irq_status_d = 16'h0000;
    // set wins over read clear
    if (cycle_end)
      irq_status_d[irq_cycle_bit] = 1'b1;
    if (trig_pulse && !secondary_gen)
      irq_status_d[irq_trigger_bit] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_status_q <= reg_reset;
    else
      irq_status_q <= irq_status_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(irq_status_d & irq_mask_q);
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_duty_high;
    @(posedge clk) disable iff (!rst_b)
      (gen_en && pairing == pairing_redundant && pulse) |=> (high_side_output && low_side_output);
  endproperty
  a_duty_high: assert property (p_duty_high)
    else $error("outputs not high inside duty window");

  property p_complement;
    @(posedge clk) disable iff (!rst_b)
      (gen_en && $past(gen_en) && pairing == pairing_complementary
        && $stable(pairing)) |-> (high_side_output != low_side_output);
  endproperty
  a_complement: assert property (p_complement)
    else $error("complementary outputs overlap");

  property p_phase_load;
    @(posedge clk) disable iff (!rst_b)
      (start && !ipsel && phase_used) |=> (cnt_q == $past(phase_offset_q));
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("phase shift not applied at enable");

  property p_own_period;
    @(posedge clk) disable iff (!rst_b)
      (gen_en && !start && ipsel && phase_used && cnt_q == phase_offset_q)
        |=> (cnt_q == 16'h0000);
  endproperty
  a_own_period: assert property (p_own_period)
    else $error("independent period not honoured");

  property p_trig_follows;
    @(posedge clk) disable iff (!rst_b)
      trig_pulse |=> trigger_out;
  endproperty
  a_trig_follows: assert property (p_trig_follows)
    else $error("trigger output lost");

  property p_no_trig_at_start;
    @(posedge clk) disable iff (!rst_b)
      start |=> !trigger_out ##1 !trigger_out;
  endproperty
  a_no_trig_at_start: assert property (p_no_trig_at_start)
    else $error("trigger right after enable");

  property p_secondary_quiet;
    @(posedge clk) disable iff (!rst_b)
      secondary_gen |-> !irq_status_q[irq_trigger_bit];
  endproperty
  a_secondary_quiet: assert property (p_secondary_quiet)
    else $error("secondary raised trigger interrupt");

  property p_primary_flag;
    @(posedge clk) disable iff (!rst_b)
      (!secondary_gen && trig_pulse) |=> irq_status_q[irq_trigger_bit];
  endproperty
  a_primary_flag: assert property (p_primary_flag)
    else $error("primary trigger not flagged");

  property p_start_clear;
    @(posedge clk) disable iff (!rst_b)
      start |=> !trig_pulse;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("postscaler not restarted on enable");

  c_trigger: cover property (@(posedge clk) disable iff (!rst_b) trigger_out);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
  c_own_period: cover property (@(posedge clk) disable iff (!rst_b) cycle_end && ipsel);
  c_push_pull: cover property (@(posedge clk) disable iff (!rst_b)
    low_side_output && pairing == pairing_push_pull);
endmodule
`default_nettype wire

/* design/pwm_pkg.sv */
package pwm_pkg;
  // -----------------------------------------------------------------
  // register bus
  // -----------------------------------------------------------------
  localparam int addr_width = 8;
  localparam int data_width = 16;
  localparam logic [7:0] duty_value_addr = 8'h00;
  localparam logic [7:0] phase_offset_addr = 8'h02;
  localparam logic [7:0] trigger_control_addr = 8'h04;
  localparam logic [7:0] generator_control_addr = 8'h06;
  localparam logic [7:0] output_control_addr = 8'h08;
  localparam logic [7:0] period_value_addr = 8'h0a;
  localparam logic [7:0] irq_status_addr = 8'h0c;
  localparam logic [7:0] irq_mask_addr = 8'h0e;
  localparam logic [15:0] reg_reset = 16'h0000;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int gen_enable_bit = 15;
  localparam int independent_period_select_bit = 9;
  localparam int output_pairing_hi = 11;
  localparam int output_pairing_lo = 10;
  localparam int trigger_divide_hi = 15;
  localparam int trigger_divide_lo = 12;
  localparam int trigger_start_delay_hi = 5;
  localparam int trigger_start_delay_lo = 0;
  localparam logic [15:0] trigger_control_mask = 16'hf03f;
  localparam logic [15:0] generator_control_mask = 16'h8200;
  localparam logic [15:0] output_control_mask = 16'h0c00;
  // -----------------------------------------------------------------
  // interrupt status bits
  // -----------------------------------------------------------------
  localparam int irq_cycle_bit = 0;
  localparam int irq_trigger_bit = 1;
  localparam logic [15:0] irq_bits_mask = 16'h0003;
  // -----------------------------------------------------------------
  // output pairing encodings
  // -----------------------------------------------------------------
  localparam logic [1:0] pairing_complementary = 2'h0;
  localparam logic [1:0] pairing_redundant = 2'h1;
  localparam logic [1:0] pairing_push_pull = 2'h2;
  localparam logic [1:0] pairing_independent = 2'h3;
endpackage

/* design/trig_postscaler.sv */
`timescale 1ns/1ps
`default_nettype none
module trig_postscaler
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic event_in,
  input wire logic [3:0] divide,
  input wire logic [5:0] start_delay,
  output logic trig_out
);
  logic [5:0] delay_cnt_q;
  logic [3:0] div_q;
  logic armed;

  assign armed = (delay_cnt_q >= start_delay);

  always_ff @(posedge clk)
  begin
    if (!rst_b || restart)
      delay_cnt_q <= 6'h00;
    else if (event_in && !armed)
      delay_cnt_q <= delay_cnt_q + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || restart)
    begin
      div_q <= 4'h0;
      trig_out <= 1'b0;
    end
    else
    begin
      trig_out <= 1'b0;
      if (event_in && armed)
      begin
        if (div_q >= divide)
        begin
          div_q <= 4'h0;
          trig_out <= 1'b1;
        end
        else
          div_q <= div_q + 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_divide_hold;
    @(posedge clk) disable iff (!rst_b)
      (event_in && armed && !restart && div_q < divide) |=> !trig_out;
  endproperty
  a_divide_hold: assert property (p_divide_hold)
    else $error("trigger passed before divide count reached");

  property p_divide_pass;
    @(posedge clk) disable iff (!rst_b)
      (event_in && armed && !restart && div_q == divide) |=> (trig_out && div_q == 4'h0);
  endproperty
  a_divide_pass: assert property (p_divide_pass)
    else $error("trigger missing at divide count");

  property p_delay_block;
    @(posedge clk) disable iff (!rst_b)
      (event_in && !armed) |=> !trig_out;
  endproperty
  a_delay_block: assert property (p_delay_block)
    else $error("trigger during start delay");

  property p_restart_clear;
    @(posedge clk) disable iff (!rst_b)
      restart |=> (delay_cnt_q == 6'h00 && div_q == 4'h0 && !trig_out);
  endproperty
  a_restart_clear: assert property (p_restart_clear)
    else $error("counters not cleared on enable");

  c_trig_after_delay: cover property (@(posedge clk) disable iff (!rst_b)
    (start_delay != 6'h00 && divide != 4'h0) ##1 trig_out);
endmodule
`default_nettype wire

/* test/gate_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model
(
  input wire logic clk,
  input wire logic clear,
  input wire logic high_gate,
  input wire logic low_gate,
  output logic [7:0] high_count,
  output logic [7:0] low_count,
  output logic [7:0] both_count
);
  // ----------------------------------------
  // on-time tally of the two switches
  // ----------------------------------------
  // both_count is shoot-through exposure; a real bridge would short the rail
  always_ff @(posedge clk)
  begin
    if (clear)
    begin
      high_count <= 8'h00;
      low_count <= 8'h00;
      both_count <= 8'h00;
    end
    else
    begin
      high_count <= high_count + {7'h00, high_gate};
      low_count <= low_count + {7'h00, low_gate};
      both_count <= both_count + {7'h00, high_gate & low_gate};
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pwm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic clr = 1'b1;
  logic [15:0] rd_data;
  logic [15:0] rd_data_sec;
  logic high_side_output;
  logic low_side_output;
  logic trigger_out;
  logic trigger_out_sec;
  logic irq;
  logic irq_sec;
  logic [7:0] high_count;
  logic [7:0] low_count;
  logic [7:0] both_count;
  int fail_count = 0;
  int compares = 0;

  pwm_duty_phase_trigger #(.secondary_gen(1'b0)) i_pwm_duty_phase_trigger (.clk(clk),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .high_side_output(high_side_output),
    .low_side_output(low_side_output), .trigger_out(trigger_out), .irq(irq));
  // secondary shares the bus so every write lands in both
  pwm_duty_phase_trigger #(.secondary_gen(1'b1)) i_pwm_duty_phase_trigger_sec (.clk(clk),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data_sec), .high_side_output(), .low_side_output(), .trigger_out(trigger_out_sec),
    .irq(irq_sec));
  gate_driver_model i_gate_driver_model (.clk(clk), .clear(clr),
    .high_gate(high_side_output), .low_gate(low_side_output), .high_count(high_count),
    .low_count(low_count), .both_count(both_count));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [15:0] d2);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
    d2 = rd_data_sec;
  endtask

  // disable first so the enable edge restarts both counters
  task automatic setup(input logic [1:0] p, input logic s, input logic [15:0] ph,
    input logic [15:0] trg);
    wr(generator_control_addr, 16'h0000);
    wr(output_control_addr, {4'h0, p, 10'h000});
    wr(period_value_addr, 16'h0003);
    wr(phase_offset_addr, ph);
    wr(duty_value_addr, 16'h0002);
    wr(trigger_control_addr, trg);
    wr(generator_control_addr, {6'h20, s, 9'h000});
  endtask

  task automatic wait_trig(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (trigger_out !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      fail_count++;
      $display("[FAIL] %0t no trigger", $time);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    logic [15:0] d2;
    rd(duty_value_addr, d, d2);
    check(d, reg_reset, "duty reset");
    wr(duty_value_addr, 16'hfffe);
    rd(duty_value_addr, d, d2);
    check(d, 16'hfffe, "duty rw");
    wr(trigger_control_addr, 16'hffff);
    rd(trigger_control_addr, d, d2);
    check(d, trigger_control_mask, "trigger control bits");
    wr(8'h20, 16'hffff);
    rd(8'h20, d, d2);
    check(d, 16'h0000, "unmapped read");
    $display("test regs done");
  endtask

  task automatic t_outputs();
    logic [7:0] eh[4] = '{8'h08, 8'h08, 8'h04, 8'h08};
    logic [7:0] el[4] = '{8'h08, 8'h08, 8'h04, 8'h00};
    logic [7:0] eb[4] = '{8'h00, 8'h08, 8'h00, 8'h00};
    for (int p = 0; p < 4; p++)
    begin
      setup(p[1:0], 1'b0, 16'h0000, 16'h0000);
      repeat (8) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (16) @(posedge clk);
      #1;
      check({8'h00, high_count}, {8'h00, eh[p]}, "high on time");
      check({8'h00, low_count}, {8'h00, el[p]}, "low on time");
      check({8'h00, both_count}, {8'h00, eb[p]}, "overlap");
    end
    $display("test outputs done");
  endtask

  task automatic t_period();
    int n;
    logic [15:0] trg[3] = '{16'h0000, 16'h1000, 16'hf000};
    for (int k = 0; k < 3; k++)
    begin
      setup(2'h0, 1'b0, 16'h0000, trg[k]);
      wait_trig(n);
      wait_trig(n);
      check(16'(n), 16'(4 * (trg[k][15:12] + 1)), "divided gap");
    end
    setup(2'h0, 1'b1, 16'h0005, 16'h0000);
    wait_trig(n);
    wait_trig(n);
    check(16'(n), 16'h0006, "own period");
    setup(2'h3, 1'b1, 16'h0005, 16'h0000);
    wait_trig(n);
    wait_trig(n);
    check(16'(n), 16'h0004, "pairing 11 ignores phase");
    $display("test period done");
  endtask

  task automatic t_delay();
    int t0;
    int n;
    setup(2'h0, 1'b0, 16'h0000, 16'h0000);
    wait_trig(t0);
    setup(2'h0, 1'b0, 16'h0002, 16'h0000);
    wait_trig(n);
    check(16'(n), 16'(t0 - 2), "phase shift");
    setup(2'h0, 1'b0, 16'h0000, 16'h0002);
    wait_trig(n);
    check(16'(n), 16'(t0 + 8), "start delay 2");
    setup(2'h0, 1'b0, 16'h0000, 16'h003f);
    wait_trig(n);
    check(16'(n), 16'(t0 + 252), "start delay 63");
    // saturated delay count must restart; divide 1 adds one more cycle
    setup(2'h0, 1'b0, 16'h0000, 16'h103f);
    wait_trig(n);
    check(16'(n), 16'(t0 + 256), "delay after re-enable");
    $display("test delay done");
  endtask

  task automatic t_irq();
    int n;
    logic [15:0] d;
    logic [15:0] d2;
    wr(irq_mask_addr, 16'h0002);
    setup(2'h0, 1'b0, 16'h0000, 16'hf000);
    wait_trig(n);
    check({15'h0000, trigger_out_sec}, 16'h0001, "secondary trigger");
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0001, "primary irq");
    check({15'h0000, irq_sec}, 16'h0000, "secondary irq");
    wr(generator_control_addr, 16'h0000);
    rd(irq_status_addr, d, d2);
    check(d & 16'h0002, 16'h0002, "primary status");
    check(d2 & 16'h0002, 16'h0000, "secondary status");
    rd(irq_status_addr, d, d2);
    check(d & 16'h0002, 16'h0000, "status cleared");
    @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0000, "irq cleared");
    wr(irq_mask_addr, 16'h0000);
    setup(2'h0, 1'b0, 16'h0000, 16'h0000);
    wait_trig(n);
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0000, "masked irq");
    $display("test irq done");
  endtask

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    clr <= 1'b0;
    t_regs();
    t_outputs();
    t_period();
    t_delay();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
